/* File: tscp_host.sv */
// Host end of the serial control port, commanded over APB
`timescale 1ns/1ps
`include "tscp_defs.svh"
module tscp_host #(
   parameter logic [7:0] HALF = `TSCP_HALF_DEF
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   tscp_if.host lnk,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output wire logic [31:0] prdata,
   output wire logic pready,
   output wire logic pslverr
);
   import tscp_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      tscp_hphase_t ph;
      logic [7:0] div;
      logic [5:0] bitn;
      logic [5:0] nbits;
      logic [31:0] ctrl;
      logic [31:0] txd;
      logic [31:0] rxd;
      logic busy;
      logic sclk;
      logic csn;
      logic so;
      logic soe;
      logic [1:0] dio_s;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } tscp_hst_t;

   tscp_hst_t q;
   tscp_hst_t n;
   logic half_end;
   logic rd;
   logic [5:0] nb;
   logic [5:0] j;

   // Bit position of frame bit i within its field
   function automatic logic [4:0] bpos(input logic [5:0] i, input logic lsbf);
      logic [5:0] k;
      k = i - `TSCP_INS_BITS;
      if (i < `TSCP_INS_BITS) begin
         return lsbf ? i[4:0] : `TSCP_INS_LAST - i[4:0];
      end
      return {k[4:3], lsbf ? k[2:0] : 3'd7 - k[2:0]};
   endfunction

   function automatic logic bval(input logic [5:0] i, input logic [31:0] c,
                                 input logic [31:0] t);
      logic [4:0] p;
      p = bpos(i, c[`TSCP_CF_LSB]);
      return (i < `TSCP_INS_BITS) ? c[p[3:0]] : t[p];
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      n = q;
      n.dio_s = {q.dio_s[0], lnk.sdio};
      half_end = q.div == HALF - 8'd1;
      rd = q.ctrl[`TSCP_RW_BIT];
      j = q.bitn + 6'd1;
      if (pwdata[`TSCP_LEN_HI:`TSCP_LEN_LO] == `TSCP_LEN_STREAM) begin
         nb = {4'd0, pwdata[`TSCP_CF_SCNT_HI:`TSCP_CF_SCNT_LO]} + 6'd1;
      end else begin
         nb = {4'd0, pwdata[`TSCP_LEN_HI:`TSCP_LEN_LO]} + 6'd1;
      end

      // APB: one setup cycle, zero-wait access phase
      n.pready = psel & ~penable;
      n.pslverr = 1'b0;
      if (psel & ~penable) begin
         unique case (paddr)
            `TSCP_APB_CTRL: n.prdata = q.ctrl;
            `TSCP_APB_TX: n.prdata = q.txd;
            `TSCP_APB_RX: n.prdata = q.rxd;
            `TSCP_APB_STAT: n.prdata = {31'd0, q.busy};
            default: begin
               n.prdata = 32'h0000_0000;
               n.pslverr = 1'b1;
            end
         endcase
      end

      unique case (q.ph)
         H_IDLE: begin
            n.div = 8'd0;
            // Orders arriving while busy are dropped silently
            if (psel & penable & q.pready & pwrite & ~q.busy) begin
               if (paddr == `TSCP_APB_TX) begin
                  n.txd = pwdata;
               end
               if (paddr == `TSCP_APB_CTRL) begin
                  n.ctrl = pwdata & ~(32'h1 << `TSCP_CF_START);
                  if (pwdata[`TSCP_CF_START]) begin
                     n.busy = 1'b1;
                     n.csn = 1'b0;
                     n.ph = H_LOW;
                     n.bitn = 6'd0;
                     n.nbits = `TSCP_INS_BITS + {nb[2:0], 3'd0};
                     n.so = bval(6'd0, pwdata, q.txd);
                     n.soe = 1'b1;
                  end
               end
            end
         end
         H_LOW: begin
            n.div = q.div + 8'd1;
            if (half_end) begin
               n.div = 8'd0;
               n.sclk = 1'b1;
               n.ph = H_HIGH;
               if (rd && q.bitn >= `TSCP_INS_BITS) begin
                  n.rxd[bpos(q.bitn, q.ctrl[`TSCP_CF_LSB])] = q.dio_s[1];
               end
            end
         end
         H_HIGH: begin
            n.div = q.div + 8'd1;
            if (half_end) begin
               n.div = 8'd0;
               n.sclk = 1'b0;
               n.bitn = j;
               n.ph = (j == q.nbits) ? H_GAP : H_LOW;
               n.so = bval(j, q.ctrl, q.txd);
               // Pin handed to the device for the read data phase
               n.soe = ~(rd && j >= `TSCP_INS_BITS) && j != q.nbits;
            end
         end
         H_GAP: begin
            n.div = q.div + 8'd1;
            if (half_end) begin
               n.div = 8'd0;
               n.csn = 1'b1;
               n.busy = 1'b0;
               n.ph = H_IDLE;
            end
         end
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '0;
         q.csn <= 1'b1;
         q.ph <= H_IDLE;
      end else if (ce) begin
         q <= n;
      end
   end

   assign lnk.sclk = q.sclk;
   assign lnk.cs_n = q.csn;
   assign lnk.h_sdio_o = q.so;
   assign lnk.h_sdio_oe = q.soe;
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;

endmodule

/* File: tscp_defs.svh */
// Constants of the three-wire serial control port, both ends
`ifndef TSCP_DEFS_SVH
`define TSCP_DEFS_SVH
// ----------------------------------------
// Register space of the device
// ----------------------------------------
`define TSCP_NREG 53
`define TSCP_ADDR_CTL 13'h0000
`define TSCP_ADDR_RDBK 13'h0004
`define TSCP_ADDR_UPD 13'h0005
`define TSCP_ADDR_RO 13'h0033
`define TSCP_ADDR_MAX 13'h0034
`define TSCP_CTL_RST 8'h18
`define TSCP_BIT_LSB 6
`define TSCP_BIT_UPD 0
`define TSCP_BIT_RDBK 0
// ----------------------------------------
// Instruction word
// ----------------------------------------
`define TSCP_INS_LAST 5'd15
`define TSCP_BYTE_LAST 5'd7
`define TSCP_BYTE_BITS 5'd8
`define TSCP_INS_BITS 6'd16
`define TSCP_RW_BIT 15
`define TSCP_LEN_HI 14
`define TSCP_LEN_LO 13
`define TSCP_ADR_HI 12
`define TSCP_LEN_STREAM 2'b11
// ----------------------------------------
// Host register map over APB
// ----------------------------------------
`define TSCP_APB_CTRL 8'h00
`define TSCP_APB_TX 8'h04
`define TSCP_APB_RX 8'h08
`define TSCP_APB_STAT 8'h0C
`define TSCP_CF_START 16
`define TSCP_CF_SCNT_HI 18
`define TSCP_CF_SCNT_LO 17
`define TSCP_CF_LSB 20
`define TSCP_HALF_DEF 8'd8
`endif

/* File: tscp_pkg.sv */
// Types shared by both ends of the serial control port
`include "tscp_defs.svh"
package tscp_pkg;
   typedef logic [`TSCP_NREG-1:0][7:0] tscp_cfg_t;
   typedef enum logic [0:0] {
      PH_INSTR = 1'b0,
      PH_DATA = 1'b1
   } tscp_dphase_t;
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_LOW = 2'b01,
      H_HIGH = 2'b10,
      H_GAP = 2'b11
   } tscp_hphase_t;
endpackage

/* File: tscp_if.sv */
// Three-wire link between host and device
`timescale 1ns/1ps
interface tscp_if;
   logic sclk;
   logic cs_n;
   logic h_sdio_o;
   logic h_sdio_oe;
   logic d_sdio_o;
   logic d_sdio_oe;
   logic sdio;
   // Undriven line reads low
   assign sdio = h_sdio_oe ? h_sdio_o : (d_sdio_oe ? d_sdio_o : 1'b0);
   modport dev (
      input sclk,
      input cs_n,
      input sdio,
      output d_sdio_o,
      output d_sdio_oe
   );
   modport host (
      output sclk,
      output cs_n,
      output h_sdio_o,
      output h_sdio_oe,
      input sdio
   );
endinterface

/* File: tscp_device.sv */
// Device end of the serial control port with shadowed register file
`timescale 1ns/1ps
`include "tscp_defs.svh"

module tscp_device (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   tscp_if.dev lnk,
   input wire logic [7:0] ro_status,
   output wire tscp_pkg::tscp_cfg_t cfg
);
   import tscp_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] sclk_s;
      logic [1:0] cs_s;
      logic [1:0] dio_s;
      logic sclk_p;
      logic cs_p;
      tscp_dphase_t ph;
      logic [4:0] cnt;
      logic [1:0] left;
      logic strm;
      logic rd;
      logic [12:0] addr;
      logic [15:0] sr;
      logic [7:0] tx;
      logic sdo;
      logic oe;
      logic drv_ok;
      tscp_cfg_t shd;
      tscp_cfg_t act;
   } tscp_dst_t;

   tscp_dst_t q;
   tscp_dst_t n;
   logic s_rise;
   logic s_fall;
   logic c_rise;
   logic lsb;
   logic abort;
   logic [4:0] idx;
   logic [12:0] nxt_addr;

   // ----------------------------------------
   // Read multiplexer
   // ----------------------------------------
   function automatic logic [7:0] rd_mux(
      input logic [12:0] a,
      input tscp_cfg_t s,
      input tscp_cfg_t ac,
      input logic [7:0] ro,
      input logic sel
   );
      logic [7:0] v;
      v = 8'h00;
      if (a == `TSCP_ADDR_RO) begin
         v = ro;
      end else if (a <= `TSCP_ADDR_MAX && a != `TSCP_ADDR_UPD) begin
         v = sel ? s[a[5:0]] : ac[a[5:0]];
      end
      return v;
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      n = q;
      n.sclk_s = {q.sclk_s[0], lnk.sclk};
      n.cs_s = {q.cs_s[0], lnk.cs_n};
      n.dio_s = {q.dio_s[0], lnk.sdio};
      n.sclk_p = q.sclk_s[1];
      n.cs_p = q.cs_s[1];
      // Clock edges count only while selected, so a stall freezes the shifter
      s_rise = q.sclk_s[1] & ~q.sclk_p & ~q.cs_s[1];
      s_fall = ~q.sclk_s[1] & q.sclk_p & ~q.cs_s[1];
      c_rise = q.cs_s[1] & ~q.cs_p;
      lsb = q.act[`TSCP_ADDR_CTL][`TSCP_BIT_LSB];
      if (q.ph == PH_INSTR) begin
         idx = lsb ? q.cnt : `TSCP_INS_LAST - q.cnt;
      end else begin
         idx = lsb ? q.cnt : `TSCP_BYTE_LAST - q.cnt;
      end
      nxt_addr = lsb ? q.addr + 13'h0001 : q.addr - 13'h0001;
      // Byte boundary is where a raised select stalls instead of aborting, except in a streamed data phase
      if (q.ph == PH_INSTR) begin
         abort = q.cnt != 5'd0 && q.cnt != `TSCP_BYTE_BITS;
      end else begin
         abort = q.cnt != 5'd0 || q.strm;
      end

      if (s_rise) begin
         n.sr[idx[3:0]] = q.dio_s[1];
         n.cnt = q.cnt + 5'd1;
         if (q.ph == PH_INSTR && q.cnt == `TSCP_INS_LAST) begin
            // Instruction complete after sixteen edges
            n.ph = PH_DATA;
            n.cnt = 5'd0;
            n.rd = n.sr[`TSCP_RW_BIT];
            n.left = n.sr[`TSCP_LEN_HI:`TSCP_LEN_LO];
            n.strm = n.left == `TSCP_LEN_STREAM;
            n.addr = n.sr[`TSCP_ADR_HI:0];
            n.drv_ok = 1'b0;
            n.tx = rd_mux(n.addr, q.shd, q.act, ro_status,
                          q.act[`TSCP_ADDR_RDBK][`TSCP_BIT_RDBK]);
         end else if (q.ph == PH_DATA && q.cnt == `TSCP_BYTE_LAST) begin
            n.cnt = 5'd0;
            if (!q.rd) begin
               if (q.addr == `TSCP_ADDR_UPD) begin
                  // Self-clearing: the update bit itself is never stored
                  if (n.sr[`TSCP_BIT_UPD]) begin
                     n.act = q.shd;
                  end
               end else if (q.addr <= `TSCP_ADDR_MAX && q.addr != `TSCP_ADDR_RO) begin
                  n.shd[q.addr[5:0]] = n.sr[7:0];
               end
            end
            n.addr = nxt_addr;
            n.tx = rd_mux(nxt_addr, q.shd, q.act, ro_status,
                          q.act[`TSCP_ADDR_RDBK][`TSCP_BIT_RDBK]);
            if (!q.strm) begin
               if (q.left == 2'b00) begin
                  // Final byte of a counted transfer ends the cycle
                  n.ph = PH_INSTR;
               end else begin
                  n.left = q.left - 2'b01;
               end
            end
         end
      end

      if (s_fall && q.ph == PH_DATA && q.rd) begin
         n.sdo = q.tx[idx[2:0]];
         n.drv_ok = 1'b1;
      end

      // Rise off a boundary: partial bits dropped, back to instruction wait
      if (c_rise && abort) begin
         n.ph = PH_INSTR;
         n.cnt = 5'd0;
      end

      // Pin taken only after the first read fall, once the host has let go
      n.oe = ~q.cs_s[1] & (n.ph == PH_DATA) & n.rd & n.drv_ok;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '0;
         q.cs_s <= 2'b11;
         q.cs_p <= 1'b1;
         q.ph <= PH_INSTR;
         q.shd[`TSCP_ADDR_CTL] <= `TSCP_CTL_RST;
         q.act[`TSCP_ADDR_CTL] <= `TSCP_CTL_RST;
      end else if (ce) begin
         q <= n;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign lnk.d_sdio_o = q.sdo;
   assign lnk.d_sdio_oe = q.oe;
   assign cfg = q.act;

endmodule

/* File: tscp_props.sv */
// Assertions on the host-device serial link
`timescale 1ns/1ps
module tscp_props #(
   parameter logic [7:0] HALF = 8'h08
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic h_sdio_o,
   input wire logic h_sdio_oe,
   input wire logic d_sdio_o,
   input wire logic d_sdio_oe
);
   // ------------------------------
   // Clock high-time counter
   // ------------------------------
   logic [7:0] hi_q;
   always_ff @(posedge clk) begin
      if (srst || !sclk) begin
         hi_q <= 8'h00;
      end else begin
         hi_q <= hi_q + 8'h01;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   AST_RST_IDLE: assert property (disable iff (1'h0)
      srst |=> cs_n && !sclk && !h_sdio_oe && !d_sdio_oe) else $error("link busy after reset");
   AST_PIN_REL: assert property (cs_n [*6] |-> !d_sdio_oe)
      else $error("device drives data while deselected");
   AST_NO_FIGHT: assert property (!(h_sdio_oe && d_sdio_oe))
      else $error("both ends drive data");
   AST_HOST_LAUNCH: assert property (
      h_sdio_oe && $past(h_sdio_oe) && $changed(h_sdio_o) |-> $fell(sclk))
      else $error("host data moved off the falling edge");
   AST_DEV_LAUNCH: assert property (
      d_sdio_oe && $past(d_sdio_oe) && $changed(d_sdio_o) |-> !sclk && $past(sclk, 6))
      else $error("read bit launched late or on high clock");
   AST_READ_OE: assert property ($rose(d_sdio_oe) |-> !cs_n && !sclk && !h_sdio_oe)
      else $error("device enabled outside read phase");
   AST_HALF: assert property ($fell(sclk) |-> hi_q == HALF)
      else $error("clock high time wrong");
   AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
      else $error("clock runs outside frame");
   AST_END_CLEAN: assert property ($rose(cs_n) |-> !sclk && !h_sdio_oe)
      else $error("frame closed mid-bit");
   AST_GAP: assert property ($rose(cs_n) |=> cs_n [*7])
      else $error("gap between frames too short");
   AST_CS_SETUP: assert property ($fell(cs_n) |-> !sclk [*8])
      else $error("clock rose too soon after select");
endmodule

/* File: testbench.sv */
// Bench: APB-driven host against device, plus a bench-driven second link
`timescale 1ns/1ps
`include "tscp_defs.svh"
module testbench;
   import tscp_pkg::*;
   logic clk, srst, ce, lclk, sv;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, ro_status;
   logic [31:0] pwdata, prdata, rx;
   tscp_cfg_t cfg, cfg2;
   int err_total, checks, cyc;
   tscp_if l1();
   tscp_if l2();
   tscp_host tscp_host_inst (.clk(clk), .srst(srst), .ce(ce), .lnk(l1.host), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   tscp_device tscp_device_inst (.clk(clk), .srst(srst), .ce(ce), .lnk(l1.dev),
      .ro_status(ro_status), .cfg(cfg));
   // Second device, link driven by the bench so it can stall and abort
   tscp_device tscp_device_inst2 (.clk(clk), .srst(srst), .ce(ce), .lnk(l2.dev),
      .ro_status(ro_status), .cfg(cfg2));
   tscp_props tscp_props_inst (.clk(clk), .srst(srst), .sclk(l1.sclk), .cs_n(l1.cs_n),
      .h_sdio_o(l1.h_sdio_o), .h_sdio_oe(l1.h_sdio_oe), .d_sdio_o(l1.d_sdio_o),
      .d_sdio_oe(l1.d_sdio_oe));
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      lclk = 1'h0;
      forever #32 lclk = ~lclk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         close_out();
      end
   end
   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
      end while (pready !== 1'h1);
      rx = prdata;
      sv = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   function automatic logic [31:0] cw(input logic rw, input logic [1:0] ln,
      input logic [12:0] a, input logic [1:0] sc);
      return {13'h0000, sc, 1'h1, rw, ln, a};
   endfunction
   // Whole frame: data first, then start, then wait for idle
   task automatic run(input logic [31:0] c, input logic [31:0] d);
      apb(1'h1, `TSCP_APB_TX, d);
      apb(1'h1, `TSCP_APB_CTRL, c);
      // A hung frame is caught by the cycle watchdog
      do begin
         apb(1'h0, `TSCP_APB_STAT, 32'h0);
      end while (rx[0] !== 1'h0);
   endtask
   task automatic rd(input logic [31:0] c);
      run(c, 32'h0);
      apb(1'h0, `TSCP_APB_RX, 32'h0);
   endtask
   task automatic upd();
      run(cw(1'h0, 2'h0, `TSCP_ADDR_UPD, 2'h0), 32'h1);
   endtask
   // Bench as link master: bits MSB first, 64 ns clock only inside frames
   task automatic bb(input logic [15:0] w, input int n);
      @(negedge lclk);
      @(posedge clk);
      l2.cs_n <= 1'h0;
      l2.h_sdio_oe <= 1'h1;
      for (int i = n - 1; i >= 0; i--) begin
         l2.h_sdio_o <= w[i];
         @(posedge lclk);
         @(posedge clk);
         l2.sclk <= 1'h1;
         @(negedge lclk);
         @(posedge clk);
         l2.sclk <= 1'h0;
      end
   endtask
   task automatic csh();
      @(negedge lclk);
      @(posedge clk);
      l2.cs_n <= 1'h1;
      l2.h_sdio_oe <= 1'h0;
      repeat (4) @(negedge lclk);
   endtask
   // ------------------------------
   // Sequence
   // ------------------------------
   initial begin
      srst = 1'h1;
      ce = 1'h1;
      ro_status = 8'h5A;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      l2.sclk = 1'h0;
      l2.cs_n = 1'h1;
      l2.h_sdio_o = 1'h0;
      l2.h_sdio_oe = 1'h0;
      repeat (8) @(posedge clk);
      srst <= 1'h0;
      chk("ctl reset", 32'h18, {24'h0, cfg[0]});
      chk("reg reset", 32'h0, {24'h0, cfg[16]});
      $display("test reset done");
      run(cw(1'h0, 2'h0, 13'h0010, 2'h0), 32'h5A);
      run(cw(1'h0, 2'h1, 13'h0012, 2'h0), 32'hE2E1);
      run(cw(1'h0, 2'h2, 13'h0022, 2'h0), 32'hC3B2A1);
      chk("active before update", 32'h0, {24'h0, cfg[34]});
      upd();
      chk("len1", 32'h5A, {24'h0, cfg[16]});
      chk("len2", 32'hE2E1, {16'h0, cfg[17], cfg[18]});
      chk("len3", 32'hC3B2A1, {8'h0, cfg[32], cfg[33], cfg[34]});
      run(cw(1'h0, 2'h3, 13'h000F, 2'h3), 32'h44332211);
      upd();
      chk("stream write", 32'h44332211, {cfg[12], cfg[13], cfg[14], cfg[15]});
      $display("test writes done");
      rd(cw(1'h1, 2'h0, 13'h0010, 2'h0));
      chk("read len1", 32'h5A, {24'h0, rx[7:0]});
      rd(cw(1'h1, 2'h1, 13'h0012, 2'h0));
      chk("read len2", 32'hE2E1, {16'h0, rx[15:0]});
      rd(cw(1'h1, 2'h2, 13'h0022, 2'h0));
      chk("read len3", 32'hC3B2A1, {8'h0, rx[23:0]});
      rd(cw(1'h1, 2'h3, 13'h000F, 2'h3));
      chk("read stream", 32'h44332211, rx);
      $display("test reads done");
      run(cw(1'h0, 2'h0, 13'h0030, 2'h0), 32'h77);
      rd(cw(1'h1, 2'h0, 13'h0030, 2'h0));
      chk("read active", 32'h0, {24'h0, rx[7:0]});
      run(cw(1'h0, 2'h0, `TSCP_ADDR_RDBK, 2'h0), 32'h1);
      upd();
      run(cw(1'h0, 2'h0, 13'h0030, 2'h0), 32'h3C);
      rd(cw(1'h1, 2'h0, 13'h0030, 2'h0));
      chk("read shadow", 32'h3C, {24'h0, rx[7:0]});
      chk("active kept", 32'h77, {24'h0, cfg[48]});
      apb(1'h0, 8'h40, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, sv});
      chk("unmapped data", 32'h0, rx);
      $display("test readback done");
      run(cw(1'h0, 2'h0, `TSCP_ADDR_RO, 2'h0), 32'hFF);
      upd();
      rd(cw(1'h1, 2'h0, `TSCP_ADDR_RO, 2'h0));
      chk("read-only value", 32'h5A, {24'h0, rx[7:0]});
      chk("read-only no shadow", 32'h0, {24'h0, cfg[51]});
      $display("test read-only done");
      run(cw(1'h0, 2'h0, `TSCP_ADDR_CTL, 2'h0), 32'h58);
      upd();
      chk("lsb mode on", 32'h58, {24'h0, cfg[0]});
      run(cw(1'h0, 2'h1, 13'h0014, 2'h0) | (32'h1 << `TSCP_CF_LSB), 32'hB2A1);
      run(cw(1'h0, 2'h0, `TSCP_ADDR_UPD, 2'h0) | (32'h1 << `TSCP_CF_LSB), 32'h1);
      chk("lsb write", 32'hB2A1, {16'h0, cfg[21], cfg[20]});
      rd(cw(1'h1, 2'h1, 13'h0014, 2'h0) | (32'h1 << `TSCP_CF_LSB));
      chk("lsb read", 32'hB2A1, {16'h0, rx[15:0]});
      $display("test lsb first done");
      bb(16'h0000, 8);
      csh();
      bb(16'h0011, 8);
      bb(16'h00C3, 8);
      csh();
      bb(16'h0012, 16);
      bb(16'h000F, 4);
      csh();
      bb(16'h0005, 16);
      bb(16'h0001, 8);
      csh();
      chk("stalled write", 32'hC3, {24'h0, cfg2[17]});
      chk("aborted write", 32'h0, {24'h0, cfg2[18]});
      $display("test stall and abort done");
      srst <= 1'h1;
      repeat (2) @(posedge clk);
      srst <= 1'h0;
      @(posedge clk);
      chk("ctl after reset", 32'h18, {24'h0, cfg[0]});
      chk("reg after reset", 32'h0, {24'h0, cfg[20]});
      rd(cw(1'h1, 2'h0, `TSCP_ADDR_CTL, 2'h0));
      chk("read after reset", 32'h18, {24'h0, rx[7:0]});
      $display("test mid-run reset done");
      close_out();
   end
endmodule
